/* File: bst_pkg.sv */
package bst_pkg;

	// instruction register
	localparam int unsigned IR_LEN = 3;
	localparam logic [IR_LEN-1:0] INS_EXTEST  = 3'h0;
	localparam logic [IR_LEN-1:0] INS_IDCODE  = 3'h1;
	localparam logic [IR_LEN-1:0] INS_SAMPLE  = 3'h2;
	localparam logic [IR_LEN-1:0] INS_CLAMP   = 3'h3;
	localparam logic [IR_LEN-1:0] INS_HIGHZ   = 3'h4;
	localparam logic [IR_LEN-1:0] INS_BYPASS  = 3'h7;
	// fixed capture value, low two bits 01
	localparam logic [IR_LEN-1:0] IR_CAPTURE  = 3'h1;

	// identification register
	localparam int unsigned ID_LEN = 32;
	// value is arbitrary, bit 0 set as the id format demands
	localparam logic [ID_LEN-1:0] ID_DEFAULT  = 32'h0A5C_3001;

	localparam logic BYPASS_CAPTURE = 1'b0;

	// gray codes along the usual walk through the controller
	typedef enum logic [3:0] {
		ST_RESET    = 4'h0,
		ST_IDLE     = 4'h1,
		ST_SEL_DR   = 4'h3,
		ST_CAP_DR   = 4'h2,
		ST_SHIFT_DR = 4'h6,
		ST_EX1_DR   = 4'h7,
		ST_PAUSE_DR = 4'h5,
		ST_EX2_DR   = 4'h4,
		ST_UPD_DR   = 4'hC,
		ST_SEL_IR   = 4'hD,
		ST_CAP_IR   = 4'hF,
		ST_SHIFT_IR = 4'hE,
		ST_EX1_IR   = 4'hA,
		ST_PAUSE_IR = 4'hB,
		ST_EX2_IR   = 4'h9,
		ST_UPD_IR   = 4'h8
	} bst_state_t;

endpackage

/* File: bst_sync2.sv */
`timescale 1ns/10ps
module bst_sync2 #(
	parameter int unsigned WIDTH = 1
) (
	// destination clock domain
	input  wire logic             clk,
	input  wire logic             rst_n,
	// crossing data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	initial begin
		if (WIDTH < 1) begin
			$error("bst_sync2: WIDTH must be at least 1");
		end
	end

	// first stage is read by the second stage only
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule // bst_sync2

/* File: bst_dr_chain.sv */
`timescale 1ns/10ps
module bst_dr_chain #(
	parameter int unsigned WIDTH = 8,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// test clock domain
	input  wire logic             tck,
	input  wire logic             rst_n,
	// controller strobes, levels; capture and update for one test clock, shift for every clock of shift-DR
	input  wire logic             capture,
	input  wire logic             shift,
	input  wire logic             update,
	// serial path, lsb leaves first
	input  wire logic             serial_in,
	output logic                  serial_out,
	// parallel sides
	input  wire logic [WIDTH-1:0] par_in,
	output logic      [WIDTH-1:0] par_out
);

	initial begin
		if (WIDTH < 2) begin
			$error("bst_dr_chain: WIDTH must be at least 2");
		end
	end

	logic [WIDTH-1:0] shift_reg;
	logic [WIDTH-1:0] shift_next;

	always_comb begin
		shift_next = shift_reg;
		if (capture) begin
			shift_next = par_in;
		end else if (shift) begin
			shift_next = {serial_in, shift_reg[WIDTH-1:1]};
		end
	end

	always_ff @(posedge tck or negedge rst_n) begin
		if (!rst_n) begin
			shift_reg <= RESET_VAL;
		end else begin
			shift_reg <= shift_next;
		end
	end

	// output latch moves on the falling edge so the parallel side never sees shifting
	always_ff @(negedge tck or negedge rst_n) begin
		if (!rst_n) begin
			par_out <= RESET_VAL;
		end else if (update) begin
			par_out <= shift_reg;
		end
	end

	assign serial_out = shift_reg[0];

endmodule // bst_dr_chain

/* File: bst_tap.sv */
`timescale 1ns/10ps
// Operation
// - state moves on rising test clock by mode select
// - power-up in reset state, IDCODE current
// - select-DR goes to capture-DR or select-IR
// - capture-DR loads selected register, then shift/exit1
// - shift-DR moves selected register toward output
// - exit1-DR goes to update-DR or pause-DR
// - pause-DR holds; exit2-DR to update or shift
// - update-DR latches on falling edge, then idle/select
// - select-IR goes to capture-IR or reset
// - capture-IR loads fixed value, then exit1/shift
// - shift-IR shifts instruction, exits on high
// - exit1-IR goes to pause-IR or update-IR
// - pause-IR holds; exit2-IR to update or shift
// - update-IR falling edge makes instruction current
// - instruction register three bits, shift plus latch
// - six instruction codes select their registers
// - sample/preload samples pins, shifts boundary chain
// - extest drives outputs from boundary latches
// - bypass uses one-bit register, device unaffected
// - idcode captures and shifts identification code
// - highz floats outputs, bypass in path
// - clamp drives held boundary values via bypass
// - test reset clears only test logic
// - power-on reset also clears test logic
// - identification register 32 bits with latch
module bst_tap #(
	parameter int unsigned          PIN_IN_W  = 8,
	parameter int unsigned          PIN_OUT_W = 8,
	parameter logic [bst_pkg::ID_LEN-1:0] DEVICE_ID = bst_pkg::ID_DEFAULT
) (
	// system clock and power-on reset
	input  wire logic                 sys_clk,
	input  wire logic                 nrst,
	// test port pins
	input  wire logic                 test_clock_in,
	input  wire logic                 test_reset_n,
	input  wire logic                 test_mode_select,
	input  wire logic                 test_data_in,
	output logic                      test_data_out,
	output logic                      test_data_out_oe_n,
	// device core side
	input  wire logic [PIN_IN_W-1:0]  pin_in,
	input  wire logic [PIN_OUT_W-1:0] core_out,
	// device output pins
	output logic      [PIN_OUT_W-1:0] pin_out,
	output logic                      pin_out_oe_n
);

	localparam int unsigned BSR_W = PIN_IN_W + PIN_OUT_W;

	initial begin
		if (PIN_IN_W < 1 || PIN_OUT_W < 1) begin
			$error("bst_tap: pin widths must be at least 1");
		end
		if (DEVICE_ID[0] != 1'b1) begin
			$error("bst_tap: DEVICE_ID bit 0 must be set");
		end
	end

	// test logic falls to either the test reset pin or power-on reset
	logic tap_rst_n;
	assign tap_rst_n = test_reset_n & nrst;

	// rising test clock state
	typedef struct packed {
		bst_pkg::bst_state_t         state;
		logic [bst_pkg::IR_LEN-1:0]  ir_shift;
		logic                        bypass;
	} bst_pos_t;

	// falling test clock state
	typedef struct packed {
		logic [bst_pkg::IR_LEN-1:0]  ir_cur;
		logic                        drive_scan;
		logic                        float_out;
		logic                        tdo;
		logic                        tdo_oe_n;
	} bst_neg_t;

	// system clock state
	typedef struct packed {
		logic [PIN_OUT_W-1:0]        pin_out;
		logic                        pin_oe_n;
	} bst_sys_t;

	bst_pos_t pos_reg;
	bst_pos_t pos_next;
	bst_neg_t neg_reg;
	bst_neg_t neg_next;
	bst_sys_t sys_reg;
	bst_sys_t sys_next;

	// instruction decode from the current instruction
	logic sel_bsr;
	logic sel_id;
	logic sel_byp;

	always_comb begin
		sel_bsr = 1'b0;
		sel_id  = 1'b0;
		sel_byp = 1'b0;
		unique case (neg_reg.ir_cur)
			bst_pkg::INS_EXTEST,
			bst_pkg::INS_SAMPLE: begin
				sel_bsr = 1'b1;
			end
			bst_pkg::INS_IDCODE: begin
				sel_id = 1'b1;
			end
			default: begin
				// clamp, highz, bypass and unassigned codes
				sel_byp = 1'b1;
			end
		endcase
	end

	// pins cross into the test domain before capture
	logic [BSR_W-1:0] pins_tck;

	bst_sync2 #(
		.WIDTH(BSR_W)
	) u_pin_sync (
		.clk      (test_clock_in),
		.rst_n    (tap_rst_n),
		.async_in ({sys_reg.pin_out, pin_in}),
		.sync_out (pins_tck)
	);

	// strobes toward the data registers
	logic in_cap_dr;
	logic in_shift_dr;
	logic in_upd_dr;
	logic bsr_sout;
	logic id_sout;
	logic [BSR_W-1:0] bsr_par;

	assign in_cap_dr   = (pos_reg.state == bst_pkg::ST_CAP_DR);
	assign in_shift_dr = (pos_reg.state == bst_pkg::ST_SHIFT_DR);
	assign in_upd_dr   = (pos_reg.state == bst_pkg::ST_UPD_DR);

	// boundary chain, inputs in the low bits, outputs above
	bst_dr_chain #(
		.WIDTH     (BSR_W),
		.RESET_VAL ('0)
	) u_bsr (
		.tck        (test_clock_in),
		.rst_n      (tap_rst_n),
		.capture    (in_cap_dr & sel_bsr),
		.shift      (in_shift_dr & sel_bsr),
		.update     (in_upd_dr & sel_bsr),
		.serial_in  (test_data_in),
		.serial_out (bsr_sout),
		.par_in     (pins_tck),
		.par_out    (bsr_par)
	);

	// identification register, latch kept but nothing reads it
	bst_dr_chain #(
		.WIDTH     (bst_pkg::ID_LEN),
		.RESET_VAL (DEVICE_ID)
	) u_idr (
		.tck        (test_clock_in),
		.rst_n      (tap_rst_n),
		.capture    (in_cap_dr & sel_id),
		.shift      (in_shift_dr & sel_id),
		.update     (in_upd_dr & sel_id),
		.serial_in  (test_data_in),
		.serial_out (id_sout),
		.par_in     (DEVICE_ID),
		.par_out    ()
	);

	// controller and instruction shift stage
	always_comb begin
		pos_next = pos_reg;
		unique case (pos_reg.state)
			bst_pkg::ST_RESET: begin
				// held high, five edges from anywhere land here
				pos_next.state = test_mode_select ? bst_pkg::ST_RESET
				                                  : bst_pkg::ST_IDLE;
			end
			bst_pkg::ST_IDLE: begin
				pos_next.state = test_mode_select ? bst_pkg::ST_SEL_DR
				                                  : bst_pkg::ST_IDLE;
			end
			bst_pkg::ST_SEL_DR: begin
				pos_next.state = test_mode_select ? bst_pkg::ST_SEL_IR
				                                  : bst_pkg::ST_CAP_DR;
			end
			bst_pkg::ST_CAP_DR: begin
				pos_next.state = test_mode_select ? bst_pkg::ST_EX1_DR
				                                  : bst_pkg::ST_SHIFT_DR;
				if (sel_byp) begin
					pos_next.bypass = bst_pkg::BYPASS_CAPTURE;
				end
			end
			bst_pkg::ST_SHIFT_DR: begin
				pos_next.state = test_mode_select ? bst_pkg::ST_EX1_DR
				                                  : bst_pkg::ST_SHIFT_DR;
				if (sel_byp) begin
					pos_next.bypass = test_data_in;
				end
			end
			bst_pkg::ST_EX1_DR: begin
				pos_next.state = test_mode_select ? bst_pkg::ST_UPD_DR
				                                  : bst_pkg::ST_PAUSE_DR;
			end
			bst_pkg::ST_PAUSE_DR: begin
				pos_next.state = test_mode_select ? bst_pkg::ST_EX2_DR
				                                  : bst_pkg::ST_PAUSE_DR;
			end
			bst_pkg::ST_EX2_DR: begin
				pos_next.state = test_mode_select ? bst_pkg::ST_UPD_DR
				                                  : bst_pkg::ST_SHIFT_DR;
			end
			bst_pkg::ST_UPD_DR: begin
				pos_next.state = test_mode_select ? bst_pkg::ST_SEL_DR
				                                  : bst_pkg::ST_IDLE;
			end
			bst_pkg::ST_SEL_IR: begin
				pos_next.state = test_mode_select ? bst_pkg::ST_RESET
				                                  : bst_pkg::ST_CAP_IR;
			end
			bst_pkg::ST_CAP_IR: begin
				pos_next.state    = test_mode_select ? bst_pkg::ST_EX1_IR
				                                     : bst_pkg::ST_SHIFT_IR;
				pos_next.ir_shift = bst_pkg::IR_CAPTURE;
			end
			bst_pkg::ST_SHIFT_IR: begin
				pos_next.state    = test_mode_select ? bst_pkg::ST_EX1_IR
				                                     : bst_pkg::ST_SHIFT_IR;
				// lsb leaves first, new bit enters at the top
				pos_next.ir_shift = {test_data_in,
				                     pos_reg.ir_shift[bst_pkg::IR_LEN-1:1]};
			end
			bst_pkg::ST_EX1_IR: begin
				pos_next.state = test_mode_select ? bst_pkg::ST_UPD_IR
				                                  : bst_pkg::ST_PAUSE_IR;
			end
			bst_pkg::ST_PAUSE_IR: begin
				pos_next.state = test_mode_select ? bst_pkg::ST_EX2_IR
				                                  : bst_pkg::ST_PAUSE_IR;
			end
			bst_pkg::ST_EX2_IR: begin
				pos_next.state = test_mode_select ? bst_pkg::ST_UPD_IR
				                                  : bst_pkg::ST_SHIFT_IR;
			end
			bst_pkg::ST_UPD_IR: begin
				pos_next.state = test_mode_select ? bst_pkg::ST_SEL_DR
				                                  : bst_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge test_clock_in or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			pos_reg.state    <= bst_pkg::ST_RESET;
			pos_reg.ir_shift <= bst_pkg::IR_CAPTURE;
			pos_reg.bypass   <= bst_pkg::BYPASS_CAPTURE;
		end else begin
			pos_reg <= pos_next;
		end
	end

	// instruction latch, mode flags and serial output on the falling edge
	always_comb begin
		neg_next = neg_reg;
		if (pos_reg.state == bst_pkg::ST_RESET) begin
			neg_next.ir_cur = bst_pkg::INS_IDCODE;
		end else if (pos_reg.state == bst_pkg::ST_UPD_IR) begin
			neg_next.ir_cur = pos_reg.ir_shift;
		end
		neg_next.drive_scan = (neg_next.ir_cur == bst_pkg::INS_EXTEST) ||
		                      (neg_next.ir_cur == bst_pkg::INS_CLAMP);
		neg_next.float_out  = (neg_next.ir_cur == bst_pkg::INS_HIGHZ);
		neg_next.tdo        = 1'b0;
		neg_next.tdo_oe_n   = 1'b1;
		if (pos_reg.state == bst_pkg::ST_SHIFT_IR) begin
			neg_next.tdo      = pos_reg.ir_shift[0];
			neg_next.tdo_oe_n = 1'b0;
		end else if (in_shift_dr) begin
			neg_next.tdo_oe_n = 1'b0;
			if (sel_bsr) begin
				neg_next.tdo = bsr_sout;
			end else if (sel_id) begin
				neg_next.tdo = id_sout;
			end else begin
				neg_next.tdo = pos_reg.bypass;
			end
		end
	end

	always_ff @(negedge test_clock_in or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			neg_reg.ir_cur     <= bst_pkg::INS_IDCODE;
			neg_reg.drive_scan <= 1'b0;
			neg_reg.float_out  <= 1'b0;
			neg_reg.tdo        <= 1'b0;
			neg_reg.tdo_oe_n   <= 1'b1;
		end else begin
			neg_reg <= neg_next;
		end
	end

	assign test_data_out      = neg_reg.tdo;
	assign test_data_out_oe_n = neg_reg.tdo_oe_n;

	// test side settings cross to the system clock; the boundary latch only
	// moves in update-DR, so a tester must allow a few system clocks to settle
	logic [PIN_OUT_W+1:0] test_sys;

	bst_sync2 #(
		.WIDTH(PIN_OUT_W + 2)
	) u_mode_sync (
		.clk      (sys_clk),
		.rst_n    (nrst),
		.async_in ({bsr_par[BSR_W-1:PIN_IN_W], neg_reg.drive_scan, neg_reg.float_out}),
		.sync_out (test_sys)
	);

	// output pin mux; core logic runs normally unless a pin mode is current
	always_comb begin
		sys_next          = sys_reg;
		sys_next.pin_oe_n = test_sys[0];
		if (test_sys[1]) begin
			sys_next.pin_out = test_sys[PIN_OUT_W+1:2];
		end else begin
			sys_next.pin_out = core_out;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sys_reg.pin_out  <= '0;
			sys_reg.pin_oe_n <= 1'b0;
		end else begin
			sys_reg <= sys_next;
		end
	end

	assign pin_out      = sys_reg.pin_out;
	assign pin_out_oe_n = sys_reg.pin_oe_n;

endmodule // bst_tap

/* File: bst_tap_asserts.sv */
`timescale 1ns/10ps
module bst_tap_asserts #(
	parameter int unsigned PIN_IN_W  = 8,
	parameter int unsigned PIN_OUT_W = 8
) (
	// clocks and resets
	input wire logic                 sys_clk,
	input wire logic                 nrst,
	input wire logic                 test_clock_in,
	input wire logic                 test_reset_n,
	// test port
	input wire logic                 test_mode_select,
	input wire logic                 test_data_in,
	input wire logic                 test_data_out,
	input wire logic                 test_data_out_oe_n,
	// pins
	input wire logic [PIN_IN_W-1:0]  pin_in,
	input wire logic [PIN_OUT_W-1:0] core_out,
	input wire logic [PIN_OUT_W-1:0] pin_out,
	input wire logic                 pin_out_oe_n
);
	sequence s_rst5;
		test_mode_select [*5];
	endsequence
	sequence s_to_dr;
		!test_mode_select ##1 test_mode_select ##1 (!test_mode_select) [*2];
	endsequence
	sequence s_to_ir;
		!test_mode_select ##1 test_mode_select [*2] ##1 (!test_mode_select) [*2];
	endsequence

	a_dr_entry: assert property (@(posedge test_clock_in) disable iff (!nrst || !test_reset_n)
		s_rst5 ##1 s_to_dr |=> !test_data_out_oe_n) else $error("shift-dr not reached");
	a_ir_entry: assert property (@(posedge test_clock_in) disable iff (!nrst || !test_reset_n)
		s_rst5 ##1 s_to_ir |=> !test_data_out_oe_n) else $error("shift-ir not reached");
	a_shift_stays: assert property (@(posedge test_clock_in) disable iff (!nrst || !test_reset_n)
		!test_data_out_oe_n && !test_mode_select |=> !test_data_out_oe_n) else $error("shift left early");
	a_shift_exit: assert property (@(posedge test_clock_in) disable iff (!nrst || !test_reset_n)
		!test_data_out_oe_n && test_mode_select |=> test_data_out_oe_n [*2]) else $error("shift kept");
	a_quiet_zero: assert property (@(posedge test_clock_in) disable iff (!nrst || !test_reset_n)
		test_data_out_oe_n |-> !test_data_out) else $error("data out not quiet");
	a_treset_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
		!test_reset_n |-> test_data_out_oe_n && !test_data_out) else $error("test reset ignored");
	a_pins_reset: assert property (@(posedge sys_clk) disable iff (!nrst)
		$rose(nrst) |-> pin_out == '0 && !pin_out_oe_n) else $error("pins not reset");
	a_core_follow: assert property (@(posedge sys_clk) disable iff (!nrst)
		(!test_reset_n) [*6] |-> pin_out == $past(core_out) && !pin_out_oe_n)
		else $error("pins not following core");
endmodule // bst_tap_asserts

bind bst_tap bst_tap_asserts #(.PIN_IN_W(PIN_IN_W), .PIN_OUT_W(PIN_OUT_W)) bst_tap_asserts_inst (
	.sys_clk(sys_clk), .nrst(nrst), .test_clock_in(test_clock_in), .test_reset_n(test_reset_n),
	.test_mode_select(test_mode_select), .test_data_in(test_data_in),
	.test_data_out(test_data_out), .test_data_out_oe_n(test_data_out_oe_n), .pin_in(pin_in),
	.core_out(core_out), .pin_out(pin_out), .pin_out_oe_n(pin_out_oe_n));

/* File: bst_tester.sv */
`timescale 1ns/10ps
module bst_tester (
	// tester drives
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	// device answers
	input  wire logic tdo,
	input  wire logic tdo_oe_n
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// clock stands still between frames; undriven data reads as unknown
	task automatic tick(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#80;
		tck = 1'b1;
		q = tdo_oe_n ? 1'bx : tdo;
		#80;
		tck = 1'b0;
	endtask

	task automatic go_reset();
		logic q;
		repeat (5) tick(1'b1, ~tdi, q);
		tick(1'b0, ~tdi, q);
	endtask

	// from idle back to idle; pidx picks a bit after which to pause
	task automatic scan(input logic ir, input int n, input logic [31:0] din, input int pidx,
		output logic [31:0] dout);
		logic q;
		dout = '0;
		tick(1'b1, ~tdi, q);
		if (ir) tick(1'b1, ~tdi, q);
		tick(1'b0, ~tdi, q);
		tick(1'b0, ~tdi, q);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1 || i == pidx, din[i], q);
			dout[i] = q;
			if (i == pidx) begin
				tick(1'b0, ~tdi, q);
				tick(1'b0, ~tdi, q);
				tick(1'b1, ~tdi, q);
				tick(1'b0, ~tdi, q);
			end
		end
		tick(1'b1, ~tdi, q);
		tick(1'b0, ~tdi, q);
	endtask
endmodule // bst_tester

/* File: bst_tap_bench.sv */
`timescale 1ns/10ps
module bst_tap_bench;
	// value is arbitrary, bit 0 set
	localparam logic [31:0] TB_ID = 32'h1357_2469;
	logic        sys_clk;
	logic        nrst;
	logic        test_reset_n;
	logic        tck;
	logic        tms;
	logic        tdi;
	logic        tdo;
	logic        tdo_oe_n;
	logic [7:0]  pin_in;
	logic [7:0]  core_out;
	logic [7:0]  pin_out;
	logic        pin_out_oe_n;
	logic [31:0] d;
	int          n_fail;
	int          checked;

	bst_tap #(.PIN_IN_W(8), .PIN_OUT_W(8), .DEVICE_ID(TB_ID)) bst_tap_inst (
		.sys_clk(sys_clk), .nrst(nrst), .test_clock_in(tck), .test_reset_n(test_reset_n),
		.test_mode_select(tms), .test_data_in(tdi), .test_data_out(tdo),
		.test_data_out_oe_n(tdo_oe_n), .pin_in(pin_in), .core_out(core_out),
		.pin_out(pin_out), .pin_out_oe_n(pin_out_oe_n));
	bst_tester bst_tester_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));

	always #12.5 sys_clk = ~sys_clk;

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	// pins settle within three system clocks of a test edge
	task automatic pins(input logic [7:0] v, input logic oe_n);
		repeat (8) @(posedge sys_clk);
		check("pin_out", {24'h0, v}, {24'h0, pin_out});
		check("pin_out_oe_n", {31'h0, oe_n}, {31'h0, pin_out_oe_n});
	endtask

	task automatic load_ir(input logic [2:0] code);
		bst_tester_inst.scan(1'b1, 3, {29'h0, code}, 0, d);
		check("ir_capture", 32'h1, d);
	endtask

	task automatic t_id();
		bst_tester_inst.go_reset();
		bst_tester_inst.scan(1'b0, 32, 32'h0, 8, d);
		check("idcode", TB_ID, d);
		pins(8'h5A, 1'b0);
	endtask

	task automatic t_bypass();
		logic [2:0] codes [3] = '{bst_pkg::INS_BYPASS, 3'h5, 3'h6};
		foreach (codes[k]) begin
			load_ir(codes[k]);
			bst_tester_inst.scan(1'b0, 8, 32'hC5, 2, d);
			check("bypass_out", 32'h8A, d);
		end
		pins(8'h5A, 1'b0);
	endtask

	task automatic t_boundary();
		load_ir(bst_pkg::INS_SAMPLE);
		bst_tester_inst.scan(1'b0, 16, 32'hA500, -1, d);
		check("sample_cap", 32'h5A3C, d);
		pins(8'h5A, 1'b0);
		load_ir(bst_pkg::INS_EXTEST);
		pins(8'hA5, 1'b0);
		bst_tester_inst.scan(1'b0, 16, 32'h9600, -1, d);
		check("extest_cap", 32'hA53C, d);
		pins(8'h96, 1'b0);
		load_ir(bst_pkg::INS_CLAMP);
		bst_tester_inst.scan(1'b0, 4, 32'hF, -1, d);
		check("clamp_path", 32'hE, d);
		pins(8'h96, 1'b0);
		load_ir(bst_pkg::INS_HIGHZ);
		pins(8'h5A, 1'b1);
		load_ir(bst_pkg::INS_EXTEST);
		bst_tester_inst.go_reset();
		pins(8'h5A, 1'b0);
	endtask

	task automatic t_treset();
		load_ir(bst_pkg::INS_BYPASS);
		@(posedge sys_clk);
		#2;
		core_out = 8'hC3;
		test_reset_n = 1'b0;
		pins(8'hC3, 1'b0);
		@(posedge sys_clk);
		#2;
		test_reset_n = 1'b1;
		bst_tester_inst.go_reset();
		bst_tester_inst.scan(1'b0, 32, 32'h0, -1, d);
		check("idcode_after", TB_ID, d);
	endtask

	task automatic close_out();
		if (n_fail == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		sys_clk = 1'b0;
		nrst = 1'b1;
		test_reset_n = 1'b1;
		// a clean falling edge once every process waits, so test flops reset without a tck edge
		#1;
		nrst = 1'b0;
		pin_in = 8'h3C;
		core_out = 8'h5A;
		n_fail = 0;
		checked = 0;
		repeat (12) @(posedge sys_clk);
		#2;
		nrst = 1'b1;
		repeat (4) @(posedge sys_clk);
		t_id();
		t_bypass();
		t_boundary();
		t_treset();
		close_out();
	end

	initial begin
		#1000000;
		n_fail++;
		close_out();
	end
endmodule // bst_tap_bench
